// File: msb_pkg.sv
// Package for the mode selector button controller.
// Assumes a single 40 MHz system clock shared by all users.
package msb_pkg;

    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned HOLD_MS         = 2000;
    localparam int unsigned IDLE_MS         = 10000;
    localparam int unsigned BLINK_MS        = 250;
    localparam int unsigned DEBOUNCE_MS     = 10;
    localparam int unsigned HOLD_CYC        = HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned IDLE_CYC        = IDLE_MS * (CLK_HZ / 1000) + 1;
    localparam int unsigned BLINK_CYC       = BLINK_MS * (CLK_HZ / 1000);
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int unsigned MODE_COUNT      = 5;

    typedef enum logic [2:0] {
        MSB_NORMAL,
        MSB_FINE,
        MSB_ALIGN,
        MSB_POINTER,
        MSB_OUTAGE
    } msb_mode_t;

    localparam msb_mode_t   RESET_MODE      = MSB_NORMAL;

    typedef struct packed {
        logic normal_transfer_mode;
        logic fine_tune_mode;
        logic alignment_mode;
        logic pointer_beam_mode;
        logic outage_latch_mode;
    } msb_leds_t;

    typedef struct packed {
        logic link_up;
        logic green_present;
        logic peer_align_req;
    } msb_link_t;

endpackage : msb_pkg

// File: msb_debounce.sv
// Button synchroniser and debouncer.
// Assumes the button is an asynchronous pin, active high when pressed.
`timescale 1ns/1ps
`default_nettype none
module msb_debounce #(
    parameter int unsigned STABLE_CYC = msb_pkg::DEBOUNCE_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic raw,
    output logic      level
);
    logic                         sync_a;
    logic                         sync_b;
    logic [$clog2(STABLE_CYC+1)-1:0] cnt;
    logic [$clog2(STABLE_CYC+1)-1:0] next_cnt;
    logic                         next_level;

    always_comb begin
        next_cnt   = '0;
        next_level = level;
        if (sync_b != level) begin
            if (cnt >= ($bits(cnt))'(STABLE_CYC - 1)) begin
                next_level = sync_b;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    // Only the second stage feeds logic [RULE_14]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            cnt    <= '0;
            level  <= 1'b0;
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
            cnt    <= next_cnt;
            level  <= next_level;
        end
    end
endmodule : msb_debounce
`default_nettype wire

// File: msb_mode_ctrl.sv
// Operating mode controller driven by one panel button.
// Assumes link status inputs are asynchronous pins; one 40 MHz clock.
//
// Contract
// (RULE_01) Each short press advances the pending mode one step down the list.
// (RULE_02) The pending mode's LED blinks while not yet committed.
// (RULE_03) After about two seconds of hold the pending LED turns steady.
// (RULE_04) Release after that hold commits the pending mode and drops the old one.
// (RULE_05) More than ten seconds without a press abandons the pending choice.
// (RULE_06) Mode changes keep data flowing unless the new mode is alignment.
// (RULE_07) Process data is blocked while alignment mode is active.
// (RULE_08) In fine-tune mode data is turned off once no green segment shows.
// (RULE_09) Committing alignment from fine-tune tells the peer, and a peer request pulls this unit in too.
// (RULE_10) Power-up always starts in normal transfer mode.
// (RULE_11) Outage-latch mode latches red on the first link loss until the mode is reset.
// (RULE_12) Normal transfer LED stays lit alongside the outage-latch LED.
// (RULE_13) List order is normal, fine-tune, alignment, pointer beam, outage latch, then wraps.
// (RULE_14) Button is synchronised and debounced; durations counted in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module msb_mode_ctrl #(
    parameter int unsigned HOLD_CYC  = msb_pkg::HOLD_CYC,
    parameter int unsigned IDLE_CYC  = msb_pkg::IDLE_CYC,
    parameter int unsigned BLINK_CYC = msb_pkg::BLINK_CYC,
    parameter int unsigned DEB_CYC   = msb_pkg::DEBOUNCE_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               button,
    input  wire msb_pkg::msb_link_t link_in,
    output msb_pkg::msb_leds_t      leds,
    output logic                    outage_red,
    output logic                    data_enable,
    output logic                    peer_align_req,
    output msb_pkg::msb_mode_t      active_mode
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum {MSB_IDLE, MSB_SEL_UP, MSB_SEL_DOWN, MSB_ARMED} msb_state_t;

    localparam int CW = $clog2(IDLE_CYC + 1);

    msb_state_t             state;
    msb_state_t             next_state;
    msb_pkg::msb_mode_t     pending;
    msb_pkg::msb_mode_t     next_pending;
    msb_pkg::msb_mode_t     next_active;
    logic [CW-1:0]          timer;
    logic [CW-1:0]          next_timer;
    logic [CW-1:0]          blink_cnt;
    logic [CW-1:0]          next_blink_cnt;
    logic                   blink;
    logic                   next_blink;
    logic                   btn;
    logic                   btn_d;
    logic [2:0]             lsync_a;
    logic [2:0]             lsync_b;
    msb_pkg::msb_link_t     lnk;
    logic                   next_red;
    logic                   next_data;
    logic                   next_peer;
    msb_pkg::msb_leds_t     next_leds;

    // Cyclic successor in list order
    function automatic msb_pkg::msb_mode_t step_mode(input msb_pkg::msb_mode_t m);
        if (m == msb_pkg::MSB_OUTAGE) begin
            step_mode = msb_pkg::MSB_NORMAL;                        // [RULE_13]
        end else begin
            step_mode = msb_pkg::msb_mode_t'(m + 3'h1);             // [RULE_01]
        end
    endfunction : step_mode

    function automatic msb_pkg::msb_leds_t onehot(input msb_pkg::msb_mode_t m);
        onehot = '0;
        case (m)
            msb_pkg::MSB_NORMAL:  onehot.normal_transfer_mode = 1'b1;
            msb_pkg::MSB_FINE:    onehot.fine_tune_mode       = 1'b1;
            msb_pkg::MSB_ALIGN:   onehot.alignment_mode       = 1'b1;
            msb_pkg::MSB_POINTER: onehot.pointer_beam_mode    = 1'b1;
            msb_pkg::MSB_OUTAGE:  onehot.outage_latch_mode    = 1'b1;
            default:              onehot = '0;
        endcase
    endfunction : onehot

    // Pointer beam and outage latch keep the normal LED lit as well
    function automatic msb_pkg::msb_leds_t lit_leds(input msb_pkg::msb_mode_t m);
        lit_leds = onehot(m);
        if (m == msb_pkg::MSB_OUTAGE || m == msb_pkg::MSB_POINTER) begin
            lit_leds.normal_transfer_mode = 1'b1;                   // [RULE_12]
        end
    endfunction : lit_leds

    ////////////////////////////////////////////////////////////////////////
    msb_debounce #(
        .STABLE_CYC (DEB_CYC)
    ) u_deb (
        .clk   (clk),
        .rst_n (rst_n),
        .raw   (button),
        .level (btn)
    );                                                              // [RULE_14]

    assign lnk = msb_pkg::msb_link_t'(lsync_b);

    ////////////////////////////////////////////////////////////////////////
    // Button state machine
    always_comb begin
        next_state     = state;
        next_pending   = pending;
        next_active    = active_mode;
        next_timer     = (timer == '1) ? timer : timer + 1'b1;
        next_peer      = 1'b0;
        case (state)
            MSB_IDLE: begin
                next_pending = active_mode;
                if (btn && !btn_d) begin
                    next_state   = MSB_SEL_DOWN;
                    next_timer   = '0;
                    next_pending = step_mode(active_mode);          // [RULE_01]
                end
            end
            MSB_SEL_UP: begin
                if (btn && !btn_d) begin
                    next_state   = MSB_SEL_DOWN;
                    next_timer   = '0;
                    next_pending = step_mode(pending);              // [RULE_01]
                end else if (timer >= CW'(IDLE_CYC)) begin
                    next_state = MSB_IDLE;                          // [RULE_05]
                end
            end
            MSB_SEL_DOWN: begin
                if (!btn) begin
                    next_state = MSB_SEL_UP;
                    next_timer = '0;
                end else if (timer >= CW'(HOLD_CYC - 1)) begin
                    next_state = MSB_ARMED;                         // [RULE_03]
                end
            end
            MSB_ARMED: begin
                if (!btn) begin
                    next_state  = MSB_IDLE;
                    next_active = pending;                          // [RULE_04]
                    next_peer   = (pending == msb_pkg::MSB_ALIGN) &&
                                  (active_mode == msb_pkg::MSB_FINE); // [RULE_09]
                end
            end
            default: next_state = MSB_IDLE;
        endcase
        // Peer request only honoured when resting in fine-tune
        if (state == MSB_IDLE && lnk.peer_align_req && active_mode == msb_pkg::MSB_FINE) begin
            next_active = msb_pkg::MSB_ALIGN;                       // [RULE_09]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and indicators
    always_comb begin
        next_blink_cnt = blink_cnt + 1'b1;
        next_blink     = blink;
        if (state == MSB_IDLE || blink_cnt >= CW'(BLINK_CYC - 1)) begin
            next_blink_cnt = '0;
            next_blink     = (state == MSB_IDLE) ? 1'b1 : !blink;
        end
        // Red latches on loss, cleared only by leaving or re-entering the mode
        next_red = outage_red;
        if (next_active != msb_pkg::MSB_OUTAGE || (state == MSB_ARMED && !btn)) begin
            next_red = 1'b0;
        end
        if (next_active == msb_pkg::MSB_OUTAGE && !lnk.link_up) begin
            next_red = 1'b1;                                        // [RULE_11]
        end
        case (next_active)
            msb_pkg::MSB_ALIGN: next_data = 1'b0;                   // [RULE_07]
            msb_pkg::MSB_FINE:  next_data = lnk.green_present;      // [RULE_08]
            default:            next_data = 1'b1;                   // [RULE_06]
        endcase
        next_leds = lit_leds(next_active);                          // [RULE_12]
        if (next_state == MSB_SEL_UP || next_state == MSB_SEL_DOWN) begin
            next_leds = next_blink ? onehot(next_pending) : '0;     // [RULE_02]
        end else if (next_state == MSB_ARMED) begin
            next_leds = onehot(next_pending);                       // [RULE_03]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state          <= MSB_IDLE;
            pending        <= msb_pkg::RESET_MODE;
            active_mode    <= msb_pkg::RESET_MODE;                  // [RULE_10]
            timer          <= '0;
            blink_cnt      <= '0;
            blink          <= 1'b1;
            btn_d          <= 1'b0;
            lsync_a        <= 3'h0;
            lsync_b        <= 3'h0;
            outage_red     <= 1'b0;
            data_enable    <= 1'b1;
            peer_align_req <= 1'b0;
            leds           <= msb_pkg::msb_leds_t'(5'h10);
        end else begin
            state          <= next_state;
            pending        <= next_pending;
            active_mode    <= next_active;
            timer          <= next_timer;
            blink_cnt      <= next_blink_cnt;
            blink          <= next_blink;
            btn_d          <= btn;
            lsync_a        <= link_in;
            lsync_b        <= lsync_a;
            outage_red     <= next_red;
            data_enable    <= next_data;
            peer_align_req <= next_peer;
            leds           <= next_leds;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_commit;
        state == MSB_ARMED && !btn;
    endsequence

    sequence s_press_from_idle;
        state == MSB_IDLE && btn && !btn_d && !lnk.peer_align_req;
    endsequence

    AST_STEP: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
        s_press_from_idle |=> pending == step_mode($past(active_mode)))
        else $error("press did not advance pending mode");
    AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
        (s_press_from_idle and active_mode == msb_pkg::MSB_OUTAGE) |=> pending == msb_pkg::MSB_NORMAL)
        else $error("mode list did not wrap");
    AST_COMMIT: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
        s_commit |=> active_mode == $past(pending) ##1 leds == lit_leds(active_mode))
        else $error("release did not commit pending mode");
    AST_ARM: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
        state == MSB_SEL_DOWN && btn && timer == CW'(HOLD_CYC - 1) |=> state == MSB_ARMED)
        else $error("hold did not arm commit");
    AST_ABANDON: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
        state == MSB_SEL_UP && !(btn && !btn_d) && timer >= CW'(IDLE_CYC) |=> state == MSB_IDLE && $stable(active_mode))
        else $error("idle timeout did not abandon selection");
    AST_ALIGN_BLOCK: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
        active_mode == msb_pkg::MSB_ALIGN |-> !data_enable)
        else $error("data flowing in alignment mode");
    AST_FINE_GREEN: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
        active_mode == msb_pkg::MSB_FINE && !$past(lnk.green_present) |-> !data_enable)
        else $error("data not cut without green");
    AST_OUTAGE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
        outage_red && active_mode == msb_pkg::MSB_OUTAGE && state != MSB_ARMED |=> outage_red)
        else $error("outage indication dropped");
    AST_ALONGSIDE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
        state == MSB_IDLE && $past(state) == MSB_IDLE && active_mode == msb_pkg::MSB_OUTAGE
        |-> leds.normal_transfer_mode && leds.outage_latch_mode)
        else $error("normal LED not lit with outage latch");
    AST_PEER: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
        s_commit and pending == msb_pkg::MSB_ALIGN and active_mode == msb_pkg::MSB_FINE |=> peer_align_req ##1 !peer_align_req)
        else $error("peer not told of alignment");
    AST_OTHER_DATA: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
        active_mode inside {msb_pkg::MSB_NORMAL, msb_pkg::MSB_POINTER, msb_pkg::MSB_OUTAGE} |-> data_enable)
        else $error("data cut outside alignment");
    AST_BLINK: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
        state == MSB_SEL_UP && !blink |-> leds == '0)
        else $error("pending LED not blinking");

endmodule : msb_mode_ctrl
`default_nettype wire

// File: msb_operator.sv
// Operator model: drives the panel button by hand, with contact bounce.
// Assumes the bench calls push/release_btn in sequence on one clock.
`timescale 1ns/1ps
`default_nettype none
module msb_operator (
    input  wire logic clk,
    output logic      button
);
    initial button = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Press with one bounce glitch, shorter than the debounce time
    task automatic push();
        @(negedge clk) button = 1'b1;
        @(negedge clk) button = 1'b0;
        @(negedge clk) button = 1'b1;
    endtask : push

    // Release, then stay off long enough to clear the debouncer
    task automatic release_btn();
        @(negedge clk) button = 1'b0;
        repeat (12) @(negedge clk);
    endtask : release_btn
endmodule : msb_operator
`default_nettype wire

// File: msb_mode_ctrl_tb.sv
// Self-checking bench for the mode selector controller.
// Assumes shortened counts: hold 20, idle 60, blink 4, debounce 2 cycles.
`timescale 1ns/1ps
`default_nettype none
module msb_mode_ctrl_tb;
    localparam int HOLD = 20;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               button;
    msb_pkg::msb_link_t link_in = 3'h6;
    msb_pkg::msb_leds_t leds;
    logic               outage_red;
    logic               data_enable;
    logic               peer_out;
    msb_pkg::msb_mode_t active_mode;
    int                 err_count = 0;
    int                 num_checks = 0;
    int                 peer_cnt = 0;
    int                 cur = 0;

    always #12.5 clk = ~clk;
    // Counted on the falling edge, half a cycle after launch, so the pulse is settled
    always @(negedge clk) if (peer_out === 1'b1) peer_cnt++;

    msb_operator i_msb_operator (.clk(clk), .button(button));
    msb_mode_ctrl #(.HOLD_CYC(HOLD), .IDLE_CYC(60), .BLINK_CYC(4), .DEB_CYC(2)) i_msb_mode_ctrl (
        .clk(clk), .rst_n(rst_n), .button(button), .link_in(link_in), .leds(leds),
        .outage_red(outage_red), .data_enable(data_enable), .peer_align_req(peer_out),
        .active_mode(active_mode));

    ////////////////////////////////////////////////////////////////////////
    // Expected LEDs: pointer and outage also keep normal lit
    function automatic logic [4:0] led_exp(input int m);
        logic [4:0] v;
        v = 5'h10 >> m;
        if (m >= 3) v = v | 5'h10;
        return v;
    endfunction : led_exp

    task automatic final_report();
        if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    task automatic wait_mode(input int m);
        int i;
        for (i = 0; i < 30 && active_mode !== msb_pkg::msb_mode_t'(m); i++) @(negedge clk);
        if (i == 30) begin
            err_count++;
            final_report();
        end
    endtask : wait_mode

    // Short presses then one long press; the long press also steps once
    task automatic commit(input int n);
        int p;
        int pc;
        logic steady;
        p = (cur + n + 1) % 5;
        pc = peer_cnt;
        repeat (n) begin
            i_msb_operator.push();
            repeat (8) @(negedge clk);
            i_msb_operator.release_btn();
        end
        i_msb_operator.push();
        repeat (HOLD + 10) @(negedge clk);
        steady = 1'b1;
        repeat (8) begin
            @(negedge clk);
            steady = steady & leds[4 - p];
        end
        chk(steady, 1'b1);
        i_msb_operator.release_btn();
        wait_mode(p);
        chk(active_mode, p[2:0]);
        chk(leds, led_exp(p));
        chk(data_enable, p != 2);
        chk(8'(peer_cnt - pc), 8'(cur == 1 && p == 2));
        cur = p;
    endtask : commit

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int on;
        void'($urandom(30));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(active_mode, 3'h0);
        chk(leds, 5'h10);
        chk({outage_red, data_enable, peer_out}, 3'h2);
        // Pending selection blinks, then lapses without a commit
        i_msb_operator.push();
        repeat (8) @(negedge clk);
        i_msb_operator.release_btn();
        on = 0;
        repeat (16) begin
            @(negedge clk);
            if (leds[3] === 1'b1) on++;
        end
        chk(on > 0 && on < 16, 1'b1);
        repeat (70) @(negedge clk);
        chk(active_mode, 3'h0);
        chk(leds, 5'h10);
        // Walk the whole list and wrap; outage latch checked on the way
        repeat (5) begin
            commit(0);
            if (cur == 4) begin
                link_in.link_up = 1'b0;
                repeat (10) @(negedge clk);
                link_in.link_up = 1'b1;
                repeat (10) @(negedge clk);
                chk(outage_red, 1'b1);
                chk(leds[4], 1'b1);
            end
        end
        chk(outage_red, 1'b0);
        // Fine-tune: loss of green stops data; peer request pulls to alignment
        commit(0);
        link_in.green_present = 1'b0;
        repeat (8) @(negedge clk);
        chk(data_enable, 1'b0);
        link_in.green_present = 1'b1;
        link_in.peer_align_req = 1'b1;
        repeat (8) @(negedge clk);
        link_in.peer_align_req = 1'b0;
        wait_mode(2);
        chk(data_enable, 1'b0);
        cur = 2;
        // Random walks with wrap-around
        repeat (8) commit($urandom % 4);
        final_report();
    end
endmodule : msb_mode_ctrl_tb
`default_nettype wire
